//--- rtl/alu_exec_pkg.sv
// Opcodes, carriers and constants of the execution unit
package alu_exec_pkg;

    // ==========================================================
    // Operations handed over by the decoder
    typedef enum logic [4:0] {
        OP_PHRASE_LOAD,
        OP_MATRIX_MULTIPLY_START,
        OP_MOVE,
        OP_MOVE_PC,
        OP_MOVE_FROM_ALT_BANK,
        OP_MOVE_TO_ALT_BANK,
        OP_IMMEDIATE_LONG_LOAD,
        OP_QUICK_SMALL_LOAD,
        OP_FLOAT_MANTISSA_EXTRACT,
        OP_UNSIGNED_SHORT_PRODUCT,
        OP_NEGATE,
        OP_NORMALISE_AMOUNT,
        OP_INVERT,
        OP_CLAMP_BYTE,
        OP_CLAMP_HALFWORD,
        OP_CLAMP_TRIPLE_BYTE,
        OP_REGISTER_COUNT_LOGICAL_SHIFT,
        OP_REGISTER_COUNT_ARITH_SHIFT,
        OP_IMMEDIATE_LEFT_SHIFT,
        OP_IMMEDIATE_LOGICAL_RIGHT_SHIFT,
        OP_IMMEDIATE_ARITH_RIGHT_SHIFT,
        OP_STORE_LONG,
        OP_STORE_INDEXED_IMM,
        OP_STORE_INDEXED_REG
    } op_t;

    // ==========================================================
    // Carriers
    typedef struct packed {
        logic valid;
        op_t op;
        logic [4:0] src;
        logic [4:0] dst;
        logic base_hi;
    } issue_t;

    // Packed so that z is bit 0, c bit 1, n bit 2
    typedef struct packed {
        logic n;
        logic c;
        logic z;
    } flags_t;

    typedef struct packed {
        logic valid;
        logic write;
        logic phrase;
        logic [31:0] addr;
        logic [31:0] wdata;
    } mem_req_t;

    // ==========================================================
    // Constants
    localparam logic [4:0] BASE_LO_IDX = 5'h0e;
    localparam logic [4:0] BASE_HI_IDX = 5'h0f;
    localparam logic [31:0] SHIFT_LIMIT = 32'h0000_0020;
    localparam logic [31:0] MANT_MSB = 32'h0000_0017;
    localparam logic [31:0] BYTE_MAX = 32'h0000_00ff;
    localparam logic [31:0] HALF_MAX = 32'h0000_ffff;
    localparam logic [31:0] TRIPLE_MAX = 32'h00ff_ffff;
    localparam logic [31:0] PC_PIPE_ADJ = 32'h0000_0004;
    localparam logic [31:0] LOCAL_BASE = 32'h0000_0000;
    localparam logic [31:0] LOCAL_MASK = 32'hffff_0000;
    localparam int LONG_SHIFT = 2;
    localparam int HALF_SHIFT = 1;

endpackage

//--- rtl/alu_move_shift_store.sv
// Execution unit for moves, ALU ops, shifts, matrix multiply and stores
`timescale 1ns/1ns

// Behaviour
// - phrase load: low half to register, high half only outside local region
// - matrix flags from last step
// - move PC gives own address
// - alternate bank moves
// - immediate long: low then high
// - quick load zero-extends field
// - mantissa extract, bit 23
// - unsigned 16x16 product
// - negate with borrow
// - normalise amount, signed
// - invert via XOR ones
// - clamp to 255, N cleared
// - clamp to 65535, N cleared
// - clamp to 24 bits, N cleared
// - register shift both ways
// - arithmetic register shift
// - immediate left shift, 32 minus field
// - immediate right shifts
// - long store at register address
// - indexed store: base, then data
// - ALU ops write cycle 3
// - moves write cycle 2
// - offset 1..32 longs
// - flags: Z 0, C 1, N 2
module alu_move_shift_store (
    // Clock and reset
    input wire logic sys_clk_in,
    input wire logic arst_n_in,
    // Decoder side
    input wire alu_exec_pkg::issue_t issue_in,
    output logic issue_ready_out,
    input wire logic [15:0] ifetch_word_in,
    input wire logic [31:0] pc_raw_in,
    input wire logic bank_sel_in,
    // Matrix setup
    input wire logic [3:0] mtx_width_in,
    input wire logic mtx_by_column_in,
    input wire logic [31:0] mtx_addr_in,
    // Memory side
    output alu_exec_pkg::mem_req_t mem_req_out,
    input wire logic mem_ack_in,
    input wire logic [63:0] mem_rdata_in,
    // Status
    output alu_exec_pkg::flags_t flags_out,
    output logic [31:0] hi_half_out,
    output logic busy_out,
    // Register inspection
    input wire logic [4:0] peek_idx_in,
    input wire logic peek_bank_in,
    output logic [31:0] peek_data_out
);

    // ==========================================================
    // Helpers
    function automatic logic [32:0] shift_fn(input logic [31:0] v, input logic [31:0] cnt,
                                            input logic arith);
        logic [31:0] mag;
        logic [31:0] r;
        logic c;
        mag = cnt[31] ? 32'(-cnt) : cnt;
        c = cnt[31] ? v[31] : v[0];
        if (mag >= alu_exec_pkg::SHIFT_LIMIT)
            r = (arith && !cnt[31]) ? {32{v[31]}} : '0;
        else if (cnt[31])
            r = v << mag[4:0];
        else if (arith)
            r = 32'($signed(v) >>> mag[4:0]);
        else
            r = v >> mag[4:0];
        return {c, r};
    endfunction

    function automatic logic [31:0] clamp_fn(input logic [31:0] v, input logic [31:0] top);
        if (v[31])
            return 32'h0000_0000;
        else if (v > top)
            return top;
        else
            return v;
    endfunction

    function automatic logic [31:0] norm_fn(input logic [31:0] v);
        logic [31:0] pos;
        pos = alu_exec_pkg::MANT_MSB;
        for (int i = 0; i < 32; i++)
        begin
            if (v[i])
                pos = 32'(i);
        end
        return 32'(pos - alu_exec_pkg::MANT_MSB);
    endfunction

    function automatic logic [31:0] float_mantissa_extract_fn(input logic [31:0] f);
        logic [31:0] m;
        m = {8'h00, |f[30:23], f[22:0]};
        return f[31] ? 32'(-m) : m;
    endfunction

    function automatic alu_exec_pkg::flags_t zn_fn(input logic [31:0] r, input logic c);
        alu_exec_pkg::flags_t f;
        f.z = (r == 32'h0000_0000);
        f.n = r[31];
        f.c = c;
        return f;
    endfunction

    // ==========================================================
    // State
    typedef enum {
        ST_IDLE,
        ST_CYC2,
        ST_CYC3,
        ST_MEM,
        ST_MAC
    } state_t;

    state_t state_q, state_d;
    alu_exec_pkg::op_t op_q, op_d;
    logic [4:0] dst_q, dst_d;
    logic [4:0] src_q, src_d;
    logic bank_q, bank_d;
    logic [31:0] opa_q, opa_d;
    logic [31:0] opb_q, opb_d;
    logic [31:0] res_q, res_d;
    logic res_flags_q, res_flags_d;
    alu_exec_pkg::flags_t pend_q, pend_d;
    alu_exec_pkg::flags_t flags_q, flags_d;
    logic [15:0] imm_lo_q, imm_lo_d;
    logic [31:0] hi_half_q, hi_half_d;
    alu_exec_pkg::mem_req_t mem_q, mem_d;
    logic [3:0] step_q, step_d;
    logic [31:0] peek_q, peek_d;
    logic [31:0] regs_q [2][32];
    logic [31:0] regs_d [2][32];

    logic [32:0] sh;
    logic [32:0] mac_sum;
    logic [31:0] mac_prod;
    logic [15:0] reg_half;
    logic [15:0] mem_half;
    logic [31:0] reg_word;

    assign issue_ready_out = (state_q == ST_IDLE);
    assign busy_out = (state_q != ST_IDLE);
    assign mem_req_out = mem_q;
    assign flags_out = flags_q;
    assign hi_half_out = hi_half_q;
    assign peek_data_out = peek_q;

    // ==========================================================
    // Next state
    always_comb
    begin
        state_d = state_q;
        op_d = op_q;
        dst_d = dst_q;
        src_d = src_q;
        bank_d = bank_q;
        opa_d = opa_q;
        opb_d = opb_q;
        res_d = res_q;
        res_flags_d = res_flags_q;
        pend_d = pend_q;
        flags_d = flags_q;
        imm_lo_d = imm_lo_q;
        hi_half_d = hi_half_q;
        mem_d = mem_q;
        step_d = step_q;
        regs_d = regs_q;
        peek_d = regs_q[peek_bank_in][peek_idx_in];
        sh = '0;
        mac_sum = '0;
        mac_prod = '0;
        reg_word = regs_q[!bank_q][5'(src_q + 5'(step_q >> 1))];
        reg_half = step_q[0] ? reg_word[31:16] : reg_word[15:0];
        mem_half = mem_q.addr[1] ? mem_rdata_in[31:16] : mem_rdata_in[15:0];
        case (state_q)
            ST_IDLE:
            begin
                if (issue_in.valid)
                begin
                    // Cycle 1: operand reads
                    op_d = issue_in.op;
                    dst_d = issue_in.dst;
                    src_d = issue_in.src;
                    bank_d = bank_sel_in;
                    opb_d = regs_q[bank_sel_in][issue_in.dst];
                    if (issue_in.op == alu_exec_pkg::OP_MOVE_FROM_ALT_BANK)
                        opa_d = regs_q[!bank_sel_in][issue_in.src];
                    else if (issue_in.op == alu_exec_pkg::OP_STORE_INDEXED_IMM ||
                             issue_in.op == alu_exec_pkg::OP_STORE_INDEXED_REG)
                        opa_d = regs_q[bank_sel_in][issue_in.base_hi ?
                                alu_exec_pkg::BASE_HI_IDX : alu_exec_pkg::BASE_LO_IDX];
                    else
                        opa_d = regs_q[bank_sel_in][issue_in.src];
                    imm_lo_d = ifetch_word_in;
                    state_d = ST_CYC2;
                    case (issue_in.op)
                        alu_exec_pkg::OP_PHRASE_LOAD:
                        begin
                            mem_d = '{valid: 1'b1, write: 1'b0, phrase: 1'b1,
                                      addr: regs_q[bank_sel_in][issue_in.src],
                                      wdata: 32'h0000_0000};
                            state_d = ST_MEM;
                        end
                        alu_exec_pkg::OP_STORE_LONG:
                        begin
                            mem_d = '{valid: 1'b1, write: 1'b1, phrase: 1'b0,
                                      addr: regs_q[bank_sel_in][issue_in.src],
                                      wdata: regs_q[bank_sel_in][issue_in.dst]};
                            state_d = ST_MEM;
                        end
                        alu_exec_pkg::OP_MATRIX_MULTIPLY_START:
                        begin
                            res_d = 32'h0000_0000;
                            step_d = 4'h0;
                            state_d = ST_MAC;
                        end
                        default:
                        begin
                        end
                    endcase
                end
            end
            ST_CYC2:
            begin
                state_d = ST_CYC3;
                res_flags_d = 1'b1;
                res_d = 32'h0000_0000;
                pend_d = flags_q;
                case (op_q)
                    // Moves finish here and never touch the flags
                    alu_exec_pkg::OP_MOVE, alu_exec_pkg::OP_MOVE_FROM_ALT_BANK:
                    begin
                        regs_d[bank_q][dst_q] = opa_q;
                        state_d = ST_IDLE;
                    end
                    alu_exec_pkg::OP_MOVE_TO_ALT_BANK:
                    begin
                        regs_d[!bank_q][dst_q] = opa_q;
                        state_d = ST_IDLE;
                    end
                    alu_exec_pkg::OP_QUICK_SMALL_LOAD:
                    begin
                        regs_d[bank_q][dst_q] = {27'h000_0000, src_q};
                        state_d = ST_IDLE;
                    end
                    alu_exec_pkg::OP_MOVE_PC:
                    begin
                        // Raw counter runs ahead by the prefetch depth
                        regs_d[bank_q][dst_q] = 32'(pc_raw_in - alu_exec_pkg::PC_PIPE_ADJ);
                        state_d = ST_IDLE;
                    end
                    alu_exec_pkg::OP_IMMEDIATE_LONG_LOAD:
                    begin
                        res_d = {ifetch_word_in, imm_lo_q};
                        res_flags_d = 1'b0;
                    end
                    alu_exec_pkg::OP_STORE_INDEXED_IMM, alu_exec_pkg::OP_STORE_INDEXED_REG:
                    begin
                        // Cycle 2: data register read, address from base plus offset
                        mem_d.valid = 1'b1;
                        mem_d.write = 1'b1;
                        mem_d.phrase = 1'b0;
                        mem_d.wdata = regs_q[bank_q][dst_q];
                        if (op_q == alu_exec_pkg::OP_STORE_INDEXED_IMM)
                            mem_d.addr = 32'(opa_q + (32'((src_q == 5'h00) ? 6'h20 : {1'b0, src_q})
                                         << alu_exec_pkg::LONG_SHIFT));
                        else
                            mem_d.addr = 32'(opa_q + regs_q[bank_q][src_q]);
                        state_d = ST_MEM;
                    end
                    alu_exec_pkg::OP_FLOAT_MANTISSA_EXTRACT:
                    begin
                        res_d = float_mantissa_extract_fn(opa_q);
                        pend_d = zn_fn(res_d, flags_q.c);
                    end
                    alu_exec_pkg::OP_UNSIGNED_SHORT_PRODUCT:
                    begin
                        res_d = opa_q[15:0] * opb_q[15:0];
                        pend_d = zn_fn(res_d, flags_q.c);
                    end
                    alu_exec_pkg::OP_NEGATE:
                    begin
                        // Most negative value wraps back to itself
                        res_d = 32'(32'h0000_0000 - opb_q);
                        pend_d = zn_fn(res_d, opb_q != 32'h0000_0000);
                    end
                    alu_exec_pkg::OP_NORMALISE_AMOUNT:
                    begin
                        res_d = norm_fn(opa_q);
                        pend_d = zn_fn(res_d, flags_q.c);
                    end
                    alu_exec_pkg::OP_INVERT:
                    begin
                        res_d = opb_q ^ 32'hffff_ffff;
                        pend_d = zn_fn(res_d, flags_q.c);
                    end
                    alu_exec_pkg::OP_CLAMP_BYTE, alu_exec_pkg::OP_CLAMP_HALFWORD,
                    alu_exec_pkg::OP_CLAMP_TRIPLE_BYTE:
                    begin
                        res_d = clamp_fn(opb_q, (op_q == alu_exec_pkg::OP_CLAMP_BYTE) ?
                            alu_exec_pkg::BYTE_MAX : (op_q == alu_exec_pkg::OP_CLAMP_HALFWORD) ?
                            alu_exec_pkg::HALF_MAX : alu_exec_pkg::TRIPLE_MAX);
                        pend_d = zn_fn(res_d, flags_q.c);
                        pend_d.n = 1'b0;
                    end
                    alu_exec_pkg::OP_REGISTER_COUNT_LOGICAL_SHIFT,
                    alu_exec_pkg::OP_REGISTER_COUNT_ARITH_SHIFT,
                    alu_exec_pkg::OP_IMMEDIATE_LEFT_SHIFT,
                    alu_exec_pkg::OP_IMMEDIATE_LOGICAL_RIGHT_SHIFT,
                    alu_exec_pkg::OP_IMMEDIATE_ARITH_RIGHT_SHIFT:
                    begin
                        if (op_q == alu_exec_pkg::OP_REGISTER_COUNT_LOGICAL_SHIFT)
                            sh = shift_fn(opb_q, opa_q, 1'b0);
                        else if (op_q == alu_exec_pkg::OP_REGISTER_COUNT_ARITH_SHIFT)
                            sh = shift_fn(opb_q, opa_q, 1'b1);
                        else if (op_q == alu_exec_pkg::OP_IMMEDIATE_LEFT_SHIFT)
                            sh = shift_fn(opb_q, 32'({27'h000_0000, src_q} - 32'h0000_0020),
                                          1'b0);
                        else
                            sh = shift_fn(opb_q, (src_q == 5'h00) ? alu_exec_pkg::SHIFT_LIMIT :
                                          {27'h000_0000, src_q},
                                          op_q == alu_exec_pkg::OP_IMMEDIATE_ARITH_RIGHT_SHIFT);
                        res_d = sh[31:0];
                        pend_d = zn_fn(sh[31:0], sh[32]);
                    end
                    default:
                    begin
                        state_d = ST_IDLE;
                    end
                endcase
            end
            ST_CYC3:
            begin
                regs_d[bank_q][dst_q] = res_q;
                if (res_flags_q)
                    flags_d = pend_q;
                state_d = ST_IDLE;
            end
            ST_MEM:
            begin
                // Request stands until taken; flags are left alone
                if (mem_ack_in)
                begin
                    mem_d.valid = 1'b0;
                    if (op_q == alu_exec_pkg::OP_PHRASE_LOAD)
                    begin
                        regs_d[bank_q][dst_q] = mem_rdata_in[31:0];
                        if ((mem_q.addr & alu_exec_pkg::LOCAL_MASK) != alu_exec_pkg::LOCAL_BASE)
                            hi_half_d = mem_rdata_in[63:32];
                    end
                    state_d = ST_IDLE;
                end
            end
            ST_MAC:
            begin
                if (!mem_q.valid)
                begin
                    mem_d.valid = 1'b1;
                    mem_d.write = 1'b0;
                    mem_d.phrase = 1'b0;
                    mem_d.addr = 32'(mtx_addr_in + (mtx_by_column_in ?
                                 32'(step_q * mtx_width_in) << alu_exec_pkg::HALF_SHIFT :
                                 32'(step_q) << alu_exec_pkg::HALF_SHIFT));
                end
                else if (mem_ack_in)
                begin
                    mem_d.valid = 1'b0;
                    mac_prod = 32'($signed(reg_half) * $signed(mem_half));
                    mac_sum = {1'b0, res_q} + {1'b0, mac_prod};
                    res_d = mac_sum[31:0];
                    step_d = 4'(step_q + 4'h1);
                    if (step_q + 4'h1 >= mtx_width_in)
                    begin
                        res_flags_d = 1'b1;
                        pend_d = zn_fn(mac_sum[31:0], mac_sum[32]);
                        state_d = ST_CYC3;
                    end
                end
            end
            default:
            begin
                state_d = ST_IDLE;
            end
        endcase
    end

    // ==========================================================
    // Registers
    always_ff @(posedge sys_clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            state_q <= ST_IDLE;
            op_q <= alu_exec_pkg::OP_MOVE;
            dst_q <= 5'h00;
            src_q <= 5'h00;
            bank_q <= 1'b0;
            opa_q <= '0;
            opb_q <= '0;
            res_q <= '0;
            res_flags_q <= 1'b0;
            pend_q <= 3'h0;
            flags_q <= 3'h0;
            imm_lo_q <= '0;
            hi_half_q <= '0;
            mem_q <= '0;
            step_q <= 4'h0;
            peek_q <= '0;
            regs_q <= '{default: '{default: '0}};
        end
        else
        begin
            state_q <= state_d;
            op_q <= op_d;
            dst_q <= dst_d;
            src_q <= src_d;
            bank_q <= bank_d;
            opa_q <= opa_d;
            opb_q <= opb_d;
            res_q <= res_d;
            res_flags_q <= res_flags_d;
            pend_q <= pend_d;
            flags_q <= flags_d;
            imm_lo_q <= imm_lo_d;
            hi_half_q <= hi_half_d;
            mem_q <= mem_d;
            step_q <= step_d;
            peek_q <= peek_d;
            regs_q <= regs_d;
        end
    end

endmodule

//--- sim/alu_exec_chk_sva.sv
// Checker for the move/shift/store execution unit
`timescale 1ns/1ns
module alu_exec_chk (
    // Watched ports
    input wire logic sys_clk_in,
    input wire logic arst_n_in,
    input wire alu_exec_pkg::issue_t issue_in,
    input wire logic issue_ready_out,
    input wire logic busy_out,
    input wire logic mem_ack_in,
    input wire alu_exec_pkg::mem_req_t mem_req_out,
    input wire alu_exec_pkg::flags_t flags_out
);
    default clocking dc @(posedge sys_clk_in);
    endclocking
    default disable iff (!arst_n_in);
    logic take, mv, alu, st, clamp;
    alu_exec_pkg::op_t op;
    assign op = issue_in.op;
    assign take = issue_in.valid && issue_ready_out;
    assign mv = take && op inside {alu_exec_pkg::OP_MOVE, alu_exec_pkg::OP_MOVE_PC,
        alu_exec_pkg::OP_MOVE_TO_ALT_BANK, alu_exec_pkg::OP_QUICK_SMALL_LOAD};
    assign alu = take && op inside {alu_exec_pkg::OP_NEGATE, alu_exec_pkg::OP_CLAMP_BYTE,
        alu_exec_pkg::OP_IMMEDIATE_LEFT_SHIFT};
    assign st = take && op == alu_exec_pkg::OP_STORE_LONG;
    assign clamp = take && op == alu_exec_pkg::OP_CLAMP_BYTE;
    chk_ready_busy: assert property (issue_ready_out != busy_out)
        else $error("ready and busy overlap");
    chk_move_two: assert property (mv |=> !issue_ready_out ##1 issue_ready_out)
        else $error("move not done in cycle 2");
    chk_alu_three: assert property (alu |=> !issue_ready_out[*2] ##1 issue_ready_out)
        else $error("alu op not done in cycle 3");
    chk_clamp_neg: assert property (clamp |-> ##3 !flags_out.n)
        else $error("clamp left negative set");
    chk_flags_hold: assert property (mv || st |=> $stable(flags_out)[*3])
        else $error("neutral op changed flags");
    chk_mem_hold: assert property (mem_req_out.valid && !mem_ack_in |=> $stable(mem_req_out))
        else $error("memory request moved before ack");
    chk_mem_drop: assert property (mem_req_out.valid && mem_ack_in |=> !mem_req_out.valid)
        else $error("memory request kept after ack");
    chk_store_req: assert property (st |=> mem_req_out.valid && mem_req_out.write)
        else $error("store did not request a write");
    cov_store: cover property (st);
    cov_alu: cover property (alu);
    cov_slow_ack: cover property (mem_req_out.valid && !mem_ack_in ##1 mem_ack_in);
endmodule

bind alu_move_shift_store alu_exec_chk alu_exec_chk_i (.sys_clk_in, .arst_n_in, .issue_in,
    .issue_ready_out, .busy_out, .mem_ack_in, .mem_req_out, .flags_out);

//--- sim/mem_model.sv
// Memory responder, alternately prompt and slow
`timescale 1ns/1ns
module mem_model (
    // Clock and request
    input wire logic sys_clk_in,
    input wire alu_exec_pkg::mem_req_t mem_req_in,
    // Answer and last access seen, address zero for reads
    output logic mem_ack_out,
    output logic [63:0] mem_rdata_out,
    output logic [31:0] wr_addr_out,
    output logic [31:0] wr_data_out
);
    logic [3:0] wait_q = 4'h0;
    logic slow_q = 1'b0;
    logic [31:0] junk_q = 32'h0;
    assign mem_ack_out = mem_req_in.valid && wait_q == (slow_q ? 4'h3 : 4'h0);
    // Outside the ack cycle the data churns so stale values cannot pass
    assign mem_rdata_out = mem_ack_out ? {~mem_req_in.addr, mem_req_in.addr} : {junk_q, ~junk_q};
    always @(posedge sys_clk_in)
    begin
        junk_q <= junk_q + 32'h1357_9bdf;
        wait_q <= (mem_ack_out || !mem_req_in.valid) ? 4'h0 : wait_q + 4'h1;
        if (mem_ack_out)
        begin
            slow_q <= !slow_q;
            wr_addr_out <= mem_req_in.write ? mem_req_in.addr : 32'h0;
            wr_data_out <= mem_req_in.wdata;
        end
    end
endmodule

//--- sim/gpu_alu_move_shift_store_ops_test.sv
// Self-checking bench for the move/shift/store execution unit
`timescale 1ns/1ns
module gpu_alu_move_shift_store_ops_test;
    logic sys_clk_in = 1'b0;
    logic arst_n_in = 1'b0;
    alu_exec_pkg::issue_t issue_in = '0;
    logic [15:0] ifetch_word_in = 16'h0;
    logic [4:0] peek_idx_in = 5'h0;
    logic peek_bank_in = 1'b0;
    logic issue_ready_out, busy_out, mem_ack_in;
    alu_exec_pkg::mem_req_t mem_req_out;
    alu_exec_pkg::flags_t flags_out;
    logic [31:0] hi_half_out, peek_data_out, wr_addr, wr_data;
    logic [63:0] mem_rdata_in;
    int fails = 0;
    int samples_checked = 0;
    int cycles = 0;

    alu_move_shift_store alu_move_shift_store_i (.sys_clk_in, .arst_n_in, .issue_in,
        .issue_ready_out, .ifetch_word_in, .pc_raw_in(32'h2004), .bank_sel_in(1'b0),
        .mtx_width_in(4'h3), .mtx_by_column_in(1'b0), .mtx_addr_in(32'h0), .mem_req_out,
        .mem_ack_in, .mem_rdata_in, .flags_out, .hi_half_out, .busy_out, .peek_idx_in,
        .peek_bank_in, .peek_data_out);
    mem_model mem_model_i (.sys_clk_in, .mem_req_in(mem_req_out), .mem_ack_out(mem_ack_in),
        .mem_rdata_out(mem_rdata_in), .wr_addr_out(wr_addr), .wr_data_out(wr_data));

    always #25 sys_clk_in = ~sys_clk_in;
    always @(posedge sys_clk_in)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            fails++;
            end_of_test();
        end
    end

    // ==========================================================
    // Access tasks
    task automatic end_of_test;
        if (fails == 0 && samples_checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            fails++;
            $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Low word at issue edge, high word next
    task automatic run(input alu_exec_pkg::op_t op, input logic [4:0] s, input logic [4:0] d,
        input logic bh, input logic [31:0] imm);
        int n;
        n = 0;
        issue_in = {1'b1, op, s, d, bh};
        ifetch_word_in = imm[15:0];
        @(negedge sys_clk_in);
        issue_in.valid = 1'b0;
        ifetch_word_in = imm[31:16];
        while (issue_ready_out !== 1'b1 && n < 60)
        begin
            @(negedge sys_clk_in);
            n++;
        end
    endtask
    task automatic ld(input logic [4:0] r, input logic [31:0] v);
        run(alu_exec_pkg::OP_IMMEDIATE_LONG_LOAD, 5'h0, r, 1'b0, v);
    endtask
    task automatic peek(input logic b, input logic [4:0] r, input logic [31:0] exp);
        peek_bank_in = b;
        peek_idx_in = r;
        @(negedge sys_clk_in);
        check(peek_data_out, exp);
    endtask
    // Mask zero: flags must hold
    task automatic t(input alu_exec_pkg::op_t op, input logic [4:0] s, input logic [31:0] sv,
        input logic [31:0] dv, input logic [31:0] ev, input logic [2:0] fm, input logic [2:0] fe);
        logic [2:0] fb;
        ld(s, sv);
        ld(5'h03, dv);
        fb = flags_out;
        run(op, s, 5'h03, 1'b0, 32'h0);
        peek(1'b0, 5'h03, ev);
        check(fm != 3'h0 ? flags_out & fm : flags_out, fm != 3'h0 ? fe : fb);
    endtask

    // ==========================================================
    // Scenarios
    initial
    begin
        repeat (3) @(posedge sys_clk_in);
        @(negedge sys_clk_in);
        arst_n_in = 1'b1;
        t(alu_exec_pkg::OP_CLAMP_BYTE, 5'h01, 32'h0, 32'h105, 32'hff, 3'h5, 3'h0);
        t(alu_exec_pkg::OP_CLAMP_HALFWORD, 5'h01, 32'h0, 32'hffff_ffff, 32'h0, 3'h5, 3'h1);
        t(alu_exec_pkg::OP_CLAMP_TRIPLE_BYTE, 5'h01, 32'h0, 32'h100_0000, 32'hff_ffff, 3'h5, 3'h0);
        t(alu_exec_pkg::OP_NEGATE, 5'h01, 32'h0, 32'h5, 32'hffff_fffb, 3'h7, 3'h6);
        t(alu_exec_pkg::OP_INVERT, 5'h01, 32'h0, 32'h0f0f_0f0f, 32'hf0f0_f0f0, 3'h5, 3'h4);
        t(alu_exec_pkg::OP_UNSIGNED_SHORT_PRODUCT, 5'h01, 32'h1234_ffff, 32'hffff_ffff,
            32'hfffe_0001, 3'h5, 3'h4);
        t(alu_exec_pkg::OP_REGISTER_COUNT_LOGICAL_SHIFT, 5'h01, 32'h4, 32'h8000_0011,
            32'h0800_0001, 3'h7, 3'h2);
        t(alu_exec_pkg::OP_REGISTER_COUNT_LOGICAL_SHIFT, 5'h01, 32'hffff_ffff, 32'h8000_0001,
            32'h2, 3'h7, 3'h2);
        t(alu_exec_pkg::OP_REGISTER_COUNT_ARITH_SHIFT, 5'h01, 32'h4, 32'h8000_0010,
            32'hf800_0001, 3'h7, 3'h4);
        t(alu_exec_pkg::OP_IMMEDIATE_LEFT_SHIFT, 5'h1f, 32'h0, 32'h8000_0001, 32'h2, 3'h7, 3'h2);
        t(alu_exec_pkg::OP_IMMEDIATE_LOGICAL_RIGHT_SHIFT, 5'h04, 32'h0, 32'h8000_0011,
            32'h0800_0001, 3'h7, 3'h2);
        t(alu_exec_pkg::OP_IMMEDIATE_ARITH_RIGHT_SHIFT, 5'h04, 32'h0, 32'h8000_0011,
            32'hf800_0001, 3'h7, 3'h6);
        t(alu_exec_pkg::OP_FLOAT_MANTISSA_EXTRACT, 5'h01, 32'hbf80_0000, 32'h0, 32'hff80_0000,
            3'h5, 3'h4);
        t(alu_exec_pkg::OP_NORMALISE_AMOUNT, 5'h01, 32'h100_0000, 32'h0, 32'h1, 3'h5, 3'h0);
        t(alu_exec_pkg::OP_QUICK_SMALL_LOAD, 5'h11, 32'h0, 32'h7, 32'h11, 3'h0, 3'h0);
        t(alu_exec_pkg::OP_MOVE, 5'h01, 32'hcafe_0123, 32'h0, 32'hcafe_0123, 3'h0, 3'h0);
        run(alu_exec_pkg::OP_MOVE_PC, 5'h0, 5'h07, 1'b0, 32'h0);
        peek(1'b0, 5'h07, 32'h2000);
        ld(5'h08, 32'h5a5a_0001);
        run(alu_exec_pkg::OP_MOVE_TO_ALT_BANK, 5'h08, 5'h09, 1'b0, 32'h0);
        peek(1'b1, 5'h09, 32'h5a5a_0001);
        run(alu_exec_pkg::OP_MOVE_FROM_ALT_BANK, 5'h09, 5'h0a, 1'b0, 32'h0);
        peek(1'b0, 5'h0a, 32'h5a5a_0001);
        ld(5'h08, 32'hffff);
        run(alu_exec_pkg::OP_MOVE_TO_ALT_BANK, 5'h08, 5'h0b, 1'b0, 32'h0);
        run(alu_exec_pkg::OP_MATRIX_MULTIPLY_START, 5'h0a, 5'h0c, 1'b0, 32'h0);
        peek(1'b0, 5'h0c, 32'hffff_fffc);
        check(flags_out, 32'h4);
        ld(5'h04, 32'h1000);
        ld(5'h05, 32'h89ab_cdef);
        peek(1'b0, 5'h05, 32'h89ab_cdef);
        run(alu_exec_pkg::OP_STORE_LONG, 5'h04, 5'h05, 1'b0, 32'h0);
        check(wr_addr, 32'h1000);
        check(wr_data, 32'h89ab_cdef);
        ld(5'h0e, 32'h100);
        ld(5'h0f, 32'h200);
        run(alu_exec_pkg::OP_STORE_INDEXED_IMM, 5'h02, 5'h05, 1'b0, 32'h0);
        check(wr_addr, 32'h108);
        run(alu_exec_pkg::OP_STORE_INDEXED_IMM, 5'h00, 5'h05, 1'b1, 32'h0);
        check(wr_addr, 32'h280);
        ld(5'h04, 32'h20_0000);
        run(alu_exec_pkg::OP_PHRASE_LOAD, 5'h04, 5'h06, 1'b0, 32'h0);
        peek(1'b0, 5'h06, 32'h20_0000);
        check(hi_half_out, 32'hffdf_ffff);
        end_of_test();
    end
endmodule
